// ### rtl/lds_frame_slave.sv
// Frame slave of the LED driver serial control link.
`timescale 1ns/1ps
`default_nettype none
module lds_frame_slave
   import lds_pkg::*;
#(
   parameter int unsigned TMO_CYC_0   = TMO_CYC_DEF_0,
   parameter int unsigned TMO_CYC_1   = TMO_CYC_DEF_1,
   parameter int unsigned TMO_CYC_2   = TMO_CYC_DEF_2,
   parameter int unsigned TMO_CYC_3   = TMO_CYC_DEF_3,
   parameter bit          ALT_VARIANT = 1'b0
) (
   // Clock and reset.
   input  wire logic       clk_sys_i,
   input  wire logic       rst_i,
   // Serial link.
   input  wire logic       rx_i,
   output logic            tx_o,
   // Configuration.
   input  wire logic [1:0] frame_timeout_select_i,
   input  wire logic       address_source_select_i,
   input  wire logic       stored_addr_we_i,
   input  wire logic [3:0] stored_slave_address_i,
   // Address straps.
   input  wire logic       address_strap_2_i,
   input  wire logic       address_strap_1_i,
   input  wire logic       address_strap_0_i,
   // Status source.
   input  wire logic [7:0] primary_flag_register_i,
   // Register access.
   output logic            reg_we_o,
   output logic            reg_re_o,
   output logic [7:0]      reg_addr_o,
   output logic [7:0]      reg_wdata_o,
   input  wire logic [7:0] reg_rdata_i,
   // Status.
   output logic            watchdog_restart_o,
   output logic            crc_error_o,
   output logic [3:0]      slave_address_o,
   output logic            pwm_clk_o,
   output logic [1:0]      pwm_in_o
);
   if (TMO_CYC_0 < 1 || TMO_CYC_3 >= (1 << TW) || TMO_CYC_2 >= (1 << TW) ||
       TMO_CYC_1 >= (1 << TW) || TMO_CYC_0 >= (1 << TW)) begin : g_bad_tmo
      $error("Idle timeout counts out of range.");
   end

   lds_state_e    state_r;
   logic [3:0]    meta_r;
   logic [3:0]    pin_r;
   logic          rx_prev_r;
   logic [3:0]    stored_addr_r;
   logic [TW-1:0] idle_cnt_r;
   logic [SW-1:0] sync_cnt_r;
   logic [2:0]    fall_cnt_r;
   logic [PW-1:0] period_r;
   logic [3:0]    idx_r;
   logic [7:0]    devsel_r;
   logic [7:0]    ptr_r;
   logic [7:0]    data_r [DATA_MAX];
   logic [7:0]    crc_r;
   logic [7:0]    rx_crc_r;
   logic [2:0]    cnt_r;
   logic          stat_r;
   logic          tx_start_r;
   logic [7:0]    tx_byte_r;

   // Pin samples: bit 0 is the link, bits 3..1 the straps.
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         meta_r    <= 4'hf;
         pin_r     <= 4'hf;
         rx_prev_r <= 1'b1;
      end else begin
         meta_r    <= {address_strap_2_i, address_strap_1_i, address_strap_0_i, rx_i};
         pin_r     <= meta_r;
         rx_prev_r <= pin_r[0];
      end
   end

   wire logic       rx_s    = pin_r[0];
   wire logic [2:0] strap_s = pin_r[3:1];
   wire logic       rx_fall = rx_prev_r & ~rx_s;
   wire logic       rx_edge = rx_prev_r ^ rx_s;

   // Slave address and strap reuse.
   wire logic [3:0] my_addr = address_source_select_i ? stored_addr_r // [RULE18]
                                                      : {stored_addr_r[3], strap_s}; // [RULE19]

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         stored_addr_r   <= {ALT_VARIANT, STORED_LOW_RST}; // [RULE22]
         slave_address_o <= 4'h0;
         pwm_clk_o       <= 1'b0;
         pwm_in_o        <= 2'h0;
      end else begin
         if (stored_addr_we_i) begin
            stored_addr_r <= stored_slave_address_i;
         end
         slave_address_o <= my_addr; // [RULE17]
         pwm_clk_o       <= address_source_select_i & strap_s[2]; // [RULE18]
         pwm_in_o        <= address_source_select_i ? strap_s[1:0] : 2'h0;
      end
   end

   // Idle timeout while a frame is being received.
   wire logic [TW-1:0] tmo_lim = (frame_timeout_select_i == 2'h0) ? TW'(TMO_CYC_0) : // [RULE8]
                                 (frame_timeout_select_i == 2'h1) ? TW'(TMO_CYC_1) :
                                 (frame_timeout_select_i == 2'h2) ? TW'(TMO_CYC_2) :
                                                                    TW'(TMO_CYC_3);
   wire logic in_frame = (state_r == ST_SYNC) || (state_r == ST_RECV);
   wire logic tmo_hit  = in_frame && (idle_cnt_r >= tmo_lim);

   always_ff @(posedge clk_sys_i) begin
      if (rst_i || !in_frame || rx_edge) begin
         idle_cnt_r <= '0;
      end else if (!tmo_hit) begin
         idle_cnt_r <= idle_cnt_r + 1'b1;
      end
   end

   // Frame decode.
   wire logic [PW-1:0] meas_period = sync_cnt_r[SW-1:SYNC_SHIFT];
   wire logic period_ok = (meas_period >= PW'(BIT_MIN_CYC)) && (meas_period <= PW'(BIT_MAX_CYC)); // [RULE3]
   wire logic sync_ovf  = &sync_cnt_r;
   wire logic [3:0] n_data   = 4'h1 << devsel_r[DS_LEN_MSB:DS_LEN_LSB]; // [RULE14]
   wire logic       is_write = devsel_r[DS_WRITE]; // [RULE24]
   wire logic       is_bcast = devsel_r[DS_BCAST];
   wire logic [3:0] last_idx = is_write ? HDR_BYTES + n_data : HDR_BYTES;
   wire logic       crc_ok   = (rx_crc_r == crc_r);
   wire logic       addr_ok  = (devsel_r[DS_ADDR_MSB:0] == my_addr);
   wire logic       cnt_last = (cnt_r == 3'(n_data - 4'h1));
   wire logic [2:0] data_idx = 3'(idx_r - HDR_BYTES);
   wire logic       rx_en    = (state_r == ST_RECV);
   wire logic [7:0] rx_byte;
   wire logic       rx_valid;
   wire logic       rx_ferr;
   wire logic       tx_busy;

   lds_uart_rx u_rx (
      .clk_sys_i (clk_sys_i),
      .rst_i     (rst_i),
      .en_i      (rx_en),
      .period_i  (period_r),
      .line_i    (rx_s),
      .byte_o    (rx_byte),
      .valid_o   (rx_valid),
      .ferr_o    (rx_ferr)
   );

   lds_uart_tx u_tx (
      .clk_sys_i (clk_sys_i),
      .rst_i     (rst_i),
      .start_i   (tx_start_r),
      .byte_i    (tx_byte_r),
      .period_i  (period_r), // [RULE27]
      .line_o    (tx_o),
      .busy_o    (tx_busy)
   );

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         state_r            <= ST_IDLE;
         sync_cnt_r         <= '0;
         fall_cnt_r         <= 3'h0;
         period_r           <= PW'(BIT_MAX_CYC);
         idx_r              <= 4'h0;
         devsel_r           <= 8'h00;
         ptr_r              <= 8'h00;
         crc_r              <= CRC_INIT;
         rx_crc_r           <= 8'h00;
         cnt_r              <= 3'h0;
         stat_r             <= 1'b0;
         tx_start_r         <= 1'b0;
         tx_byte_r          <= 8'h00;
         reg_we_o           <= 1'b0;
         reg_re_o           <= 1'b0;
         reg_addr_o         <= 8'h00;
         reg_wdata_o        <= 8'h00;
         watchdog_restart_o <= 1'b0;
         crc_error_o        <= 1'b0;
      end else begin
         reg_we_o           <= 1'b0;
         reg_re_o           <= 1'b0;
         tx_start_r         <= 1'b0;
         watchdog_restart_o <= 1'b0;
         crc_error_o        <= 1'b0;
         case (state_r)
            ST_IDLE: begin
               if (rx_fall) begin // [RULE4]
                  state_r    <= ST_SYNC;
                  sync_cnt_r <= SW'(1);
                  fall_cnt_r <= 3'h0;
                  crc_r      <= CRC_INIT; // [RULE25]
                  idx_r      <= 4'h0;
               end
            end
            ST_SYNC: begin
               sync_cnt_r <= sync_cnt_r + 1'b1;
               if (tmo_hit || sync_ovf) begin // [RULE6]
                  state_r <= ST_IDLE;
               end else if (rx_fall) begin
                  fall_cnt_r <= fall_cnt_r + 3'h1;
                  if (fall_cnt_r == SYNC_FALLS - 3'h1) begin
                     period_r <= meas_period; // [RULE4]
                     state_r  <= period_ok ? ST_RECV : ST_IDLE; // [RULE3]
                  end
               end
            end
            ST_RECV: begin
               if (tmo_hit || rx_ferr) begin // [RULE6]
                  state_r <= ST_IDLE;
               end else if (rx_valid) begin
                  idx_r <= idx_r + 4'h1;
                  if (idx_r >= HDR_BYTES && idx_r == last_idx) begin
                     rx_crc_r <= rx_byte;
                     state_r  <= ST_CHECK; // [RULE5]
                  end else begin
                     crc_r <= lds_crc8(crc_r, rx_byte); // [RULE15]
                     if (idx_r == IDX_DEVSEL) begin
                        devsel_r <= rx_byte;
                     end else if (idx_r == IDX_PTR) begin
                        ptr_r <= rx_byte;
                     end else begin
                        data_r[data_idx] <= rx_byte;
                     end
                  end
               end
            end
            ST_CHECK: begin
               cnt_r  <= 3'h0;
               stat_r <= 1'b0;
               if (!crc_ok) begin // [RULE10]
                  crc_error_o <= 1'b1;
                  state_r     <= ST_IDLE;
               end else if (!addr_ok) begin
                  state_r <= ST_IDLE;
               end else begin
                  watchdog_restart_o <= 1'b1; // [RULE5]
                  state_r <= is_write ? ST_WRITE : (is_bcast ? ST_IDLE : ST_RDREQ);
               end
            end
            ST_WRITE: begin
               reg_we_o    <= 1'b1;
               reg_addr_o  <= ptr_r + 8'(cnt_r); // [RULE26]
               reg_wdata_o <= data_r[cnt_r];
               cnt_r       <= cnt_r + 3'h1;
               if (cnt_last) begin
                  if (is_bcast) begin
                     state_r <= ST_IDLE;
                  end else begin
                     tx_byte_r  <= primary_flag_register_i; // [RULE12]
                     tx_start_r <= 1'b1;
                     stat_r     <= 1'b1;
                     state_r    <= ST_SEND;
                  end
               end
            end
            ST_RDREQ: begin
               reg_re_o   <= 1'b1;
               reg_addr_o <= ptr_r + 8'(cnt_r); // [RULE26]
               state_r    <= ST_RDCAP;
            end
            ST_RDCAP: begin
               tx_byte_r  <= reg_rdata_i; // [RULE13]
               tx_start_r <= 1'b1;
               state_r    <= ST_SEND;
            end
            ST_SEND: begin
               if (!tx_busy && !tx_start_r) begin
                  if (stat_r) begin
                     state_r <= ST_IDLE;
                  end else if (cnt_last) begin
                     tx_byte_r  <= primary_flag_register_i; // [RULE13] [RULE16]
                     tx_start_r <= 1'b1;
                     stat_r     <= 1'b1;
                  end else begin
                     cnt_r   <= cnt_r + 3'h1;
                     state_r <= ST_RDREQ;
                  end
               end
            end
            default: begin
               state_r <= ST_IDLE;
            end
         endcase
      end
   end

   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);

   sequence s_check_pass;
      state_r == ST_CHECK && crc_ok && addr_ok;
   endsequence
   sequence s_check_fail;
      state_r == ST_CHECK && !crc_ok;
   endsequence
   sequence s_sync_done;
      (state_r == ST_SYNC) ##1 (state_r == ST_RECV);
   endsequence

   property p_pass_restart;
      s_check_pass |=> watchdog_restart_o && state_r != ST_CHECK;
   endproperty
   a_pass_restart: assert property (p_pass_restart) else $error("Good frame did not restart watchdog."); // [RULE5]

   property p_fail_silent;
      s_check_fail |=> crc_error_o && !watchdog_restart_o && state_r == ST_IDLE ##1 !tx_start_r;
   endproperty
   a_fail_silent: assert property (p_fail_silent) else $error("Bad CRC frame was not discarded."); // [RULE10]

   property p_timeout;
      tmo_hit |=> state_r == ST_IDLE;
   endproperty
   a_timeout: assert property (p_timeout) else $error("Idle timeout did not abandon frame."); // [RULE6]

   property p_period_range;
      s_sync_done |-> period_r >= PW'(BIT_MIN_CYC) && period_r <= PW'(BIT_MAX_CYC) && crc_r == CRC_INIT;
   endproperty
   a_period_range: assert property (p_period_range) else $error("Frame started with bad period or CRC."); // [RULE3] [RULE25]

   property p_strap_addr;
      !address_source_select_i |=> slave_address_o == {$past(stored_addr_r[3]), $past(strap_s)};
   endproperty
   a_strap_addr: assert property (p_strap_addr) else $error("Strap address composed wrongly."); // [RULE19]

   property p_stored_addr;
      address_source_select_i |=> slave_address_o == $past(stored_addr_r) && {pwm_clk_o, pwm_in_o} == $past(strap_s);
   endproperty
   a_stored_addr: assert property (p_stored_addr) else $error("Stored address or PWM reuse wrong."); // [RULE18]

   property p_burst_addr;
      reg_we_o ##1 reg_we_o |-> reg_addr_o == $past(reg_addr_o) + 8'h01;
   endproperty
   a_burst_addr: assert property (p_burst_addr) else $error("Burst write address not consecutive."); // [RULE26]

   property p_status_byte;
      tx_start_r && stat_r |-> tx_byte_r == $past(primary_flag_register_i);
   endproperty
   a_status_byte: assert property (p_status_byte) else $error("Status byte is not the flag register."); // [RULE16]

   property p_read_data;
      state_r == ST_RDCAP |=> tx_start_r && !stat_r && tx_byte_r == $past(reg_rdata_i);
   endproperty
   a_read_data: assert property (p_read_data) else $error("Read data byte not launched."); // [RULE13]

   property p_write_ack;
      state_r == ST_WRITE && cnt_last && !is_bcast |=> tx_start_r && stat_r ##1 tx_busy;
   endproperty
   a_write_ack: assert property (p_write_ack) else $error("Write frame not answered by status."); // [RULE12]
endmodule // lds_frame_slave
`default_nettype wire

// ### rtl/lds_pkg.sv
// Constants, states and CRC step for the LED driver serial frame slave.
// Contract
// RULE1 - Bytes: start, eight data, stop, no parity.
// RULE2 - Data bits travel least significant first.
// RULE3 - Bit timing adapts from 10 kHz to 1 MHz.
// RULE4 - Each frame opens with sync setting timing.
// RULE5 - Answer and restart watchdog only after CRC pass.
// RULE6 - Mid-frame idle past timeout abandons the frame.
// RULE7 - Host keeps byte gaps below idle timeout.
// RULE8 - Idle timeout length chosen by configuration field.
// RULE9 - Host picks longer timeout at slower rates.
// RULE10 - Failed CRC discards frame, sends nothing back.
// RULE11 - Host idles one timeout to flush frame.
// RULE12 - Write frame answered by one status byte.
// RULE13 - Readback returns data bytes then status byte.
// RULE14 - Data length is 1, 2, 4 or 8.
// RULE15 - CRC covers select, pointer, data; not sync.
// RULE16 - Status byte carries the primary flag register.
// RULE17 - Up to 16 slaves, addresses 0h to Fh.
// RULE18 - Select 1: stored address, straps become PWM.
// RULE19 - Select 0: stored bit 3 plus straps.
// RULE20 - Broadcast needs every slave at address 0h.
// RULE21 - No two slaves share one address.
// RULE22 - Stored bit 3 defaults per variant.
// RULE23 - Host sync byte is pattern 01010101.
// RULE24 - Select byte: address, length, broadcast, write.
// RULE25 - Frame CRC starts from FFh.
// RULE26 - Burst bytes use consecutive register addresses.
// RULE27 - Responses reuse measured bit period and framing.
package lds_pkg;
   localparam int          CLK_HZ      = 200_000_000;
   localparam int          CLK_MHZ     = CLK_HZ / 1_000_000;
   localparam int          BAUD_MIN_HZ = 10_000;
   localparam int          BAUD_MAX_HZ = 1_000_000;
   localparam int          BIT_MIN_CYC = CLK_HZ / BAUD_MAX_HZ;
   localparam int          BIT_MAX_CYC = CLK_HZ / BAUD_MIN_HZ;
   localparam int          PW          = $clog2(BIT_MAX_CYC + 1);
   localparam int          SYNC_SHIFT  = 3;
   localparam int          SW          = PW + SYNC_SHIFT;
   localparam logic [2:0]  SYNC_FALLS  = 3'h4;
   localparam int          TW          = 24;
   localparam int          TMO_US_0    = 50;
   localparam int          TMO_US_1    = 200;
   localparam int          TMO_US_2    = 1000;
   localparam int          TMO_US_3    = 5000;
   localparam int          TMO_CYC_DEF_0 = TMO_US_0 * CLK_MHZ;
   localparam int          TMO_CYC_DEF_1 = TMO_US_1 * CLK_MHZ;
   localparam int          TMO_CYC_DEF_2 = TMO_US_2 * CLK_MHZ;
   localparam int          TMO_CYC_DEF_3 = TMO_US_3 * CLK_MHZ;
   localparam int          DATA_BITS   = 8;
   localparam logic [3:0]  STOP_IDX    = 4'h9;
   localparam int          DATA_MAX    = 8;
   localparam logic [3:0]  IDX_DEVSEL  = 4'h0;
   localparam logic [3:0]  IDX_PTR     = 4'h1;
   localparam logic [3:0]  HDR_BYTES   = 4'h2;
   localparam int          DS_ADDR_MSB = 3;
   localparam int          DS_LEN_LSB  = 4;
   localparam int          DS_LEN_MSB  = 5;
   localparam int          DS_BCAST    = 6;
   localparam int          DS_WRITE    = 7;
   localparam logic [7:0]  CRC_INIT    = 8'hff;
   localparam logic [7:0]  CRC_POLY    = 8'h31;
   localparam logic [2:0]  STORED_LOW_RST = 3'h0;

   typedef enum logic [2:0] {
      ST_IDLE, ST_SYNC, ST_RECV, ST_CHECK, ST_WRITE, ST_RDREQ, ST_RDCAP, ST_SEND
   } lds_state_e;

   // One byte of the frame CRC, most significant bit first.
   function automatic logic [7:0] lds_crc8(input logic [7:0] crc, input logic [7:0] data);
      logic [7:0] c;
      c = crc ^ data;
      for (int i = 0; i < DATA_BITS; i++) begin
         c = c[7] ? ({c[6:0], 1'b0} ^ CRC_POLY) : {c[6:0], 1'b0};
      end
      return c;
   endfunction
endpackage

// ### rtl/lds_uart_rx.sv
// Byte receiver that samples at the measured bit period.
`timescale 1ns/1ps
`default_nettype none
module lds_uart_rx
   import lds_pkg::*;
(
   // Clock and reset.
   input  wire logic          clk_sys_i,
   input  wire logic          rst_i,
   // Control.
   input  wire logic          en_i,
   input  wire logic [PW-1:0] period_i,
   input  wire logic          line_i,
   // Received byte.
   output logic [7:0]         byte_o,
   output logic               valid_o,
   output logic               ferr_o
);
   logic          busy_r;
   logic          prev_r;
   logic [3:0]    bit_r;
   logic [PW-1:0] cnt_r;

   // The edge detector follows the line while disabled so no false start appears.
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         prev_r <= 1'b1;
      end else begin
         prev_r <= line_i;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i || !en_i) begin
         busy_r  <= 1'b0;
         bit_r   <= 4'h0;
         cnt_r   <= '0;
         byte_o  <= 8'h00;
         valid_o <= 1'b0;
         ferr_o  <= 1'b0;
      end else begin
         valid_o <= 1'b0;
         ferr_o  <= 1'b0;
         if (!busy_r) begin
            if (prev_r && !line_i) begin
               busy_r <= 1'b1;
               cnt_r  <= period_i >> 1;
               bit_r  <= 4'h0;
            end
         end else if (cnt_r != '0) begin
            cnt_r <= cnt_r - 1'b1;
         end else begin
            cnt_r <= period_i - 1'b1;
            bit_r <= bit_r + 4'h1;
            if (bit_r == 4'h0 && line_i) begin
               busy_r <= 1'b0;
            end else if (bit_r == STOP_IDX) begin // [RULE1]
               busy_r  <= 1'b0;
               valid_o <= line_i;
               ferr_o  <= !line_i;
            end else if (bit_r != 4'h0) begin
               byte_o <= {line_i, byte_o[7:1]}; // [RULE2]
            end
         end
      end
   end
endmodule // lds_uart_rx
`default_nettype wire

// ### rtl/lds_uart_tx.sv
// Byte transmitter that sends at the measured bit period.
`timescale 1ns/1ps
`default_nettype none
module lds_uart_tx
   import lds_pkg::*;
(
   // Clock and reset.
   input  wire logic          clk_sys_i,
   input  wire logic          rst_i,
   // Byte to send.
   input  wire logic          start_i,
   input  wire logic [7:0]    byte_i,
   input  wire logic [PW-1:0] period_i,
   // Line and state.
   output logic               line_o,
   output logic               busy_o
);
   logic [8:0]    sh_r;
   logic [3:0]    bit_r;
   logic [PW-1:0] cnt_r;

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         line_o <= 1'b1;
         busy_o <= 1'b0;
         sh_r   <= 9'h1ff;
         bit_r  <= 4'h0;
         cnt_r  <= '0;
      end else if (!busy_o) begin
         if (start_i) begin
            busy_o <= 1'b1;
            line_o <= 1'b0;
            sh_r   <= {1'b1, byte_i};
            bit_r  <= 4'h0;
            cnt_r  <= period_i - 1'b1;
         end
      end else if (cnt_r != '0) begin
         cnt_r <= cnt_r - 1'b1;
      end else if (bit_r == STOP_IDX) begin // [RULE1]
         busy_o <= 1'b0;
         line_o <= 1'b1;
      end else begin
         cnt_r  <= period_i - 1'b1;
         bit_r  <= bit_r + 4'h1;
         line_o <= sh_r[0]; // [RULE2]
         sh_r   <= {1'b1, sh_r[8:1]};
      end
   end
endmodule // lds_uart_tx
`default_nettype wire

// ### verification/lds_host_model.sv
// Host controller model that sends and receives link bytes.
`timescale 1ns/1ps
`default_nettype none
module lds_host_model #(
   parameter int BIT = 200
) (
   input  wire logic clk_sys_i,
   input  wire logic tx_i,
   output var logic  line_o
);
   initial line_o = 1'b1;

   // Start bit, eight data bits least significant first, stop bit, no parity.
   // Bytes of one frame follow back to back, far inside the idle timeout.
   task automatic send_byte(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         @(posedge clk_sys_i) line_o <= f[i];
         repeat (BIT - 1) @(posedge clk_sys_i);
      end
   endtask

   // Waits a bounded time for a start bit, then samples mid-bit.
   task automatic recv_byte(output logic [7:0] b, output logic ok);
      int t;
      t = 0;
      b = 8'h00;
      while (tx_i !== 1'b0 && t < 4 * BIT) begin
         @(posedge clk_sys_i);
         t++;
      end
      ok = (t < 4 * BIT);
      if (ok) begin
         repeat (BIT + BIT / 2) @(posedge clk_sys_i);
         for (int i = 0; i < 8; i++) begin
            b[i] = tx_i;
            repeat (BIT) @(posedge clk_sys_i);
         end
         ok = (tx_i === 1'b1);
         // Lets the stop bit finish so the next sync is not sent while the slave still answers.
         repeat (BIT / 2) @(posedge clk_sys_i);
      end
   endtask
endmodule // lds_host_model
`default_nettype wire

// ### verification/lds_frame_slave_test.sv
// Self-checking bench for the frame slave.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin error_cnt++; $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module lds_frame_slave_test
   import lds_pkg::*;
;
   logic       clk = 0, rst = 1, rx, tx, src = 1, we_a = 0, wd_p, crc_e, pclk, re, we;
   logic [3:0] st_a = 4'h0, sa;
   logic [2:0] strap = 3'b101;
   logic [7:0] flag = 8'h3c, addr, wdat, rdat;
   logic [1:0] pin, tsel = 2'h0;
   logic [7:0] mem [256], exp [256], wd [8];
   int         error_cnt = 0, n_checks = 0, n_wd = 0, n_crc = 0, n_re = 0;

   always #2.5 clk = ~clk;

   lds_frame_slave #(.TMO_CYC_0(5000), .TMO_CYC_1(3000)) lds_frame_slave_i (.clk_sys_i(clk), .rst_i(rst),
      .rx_i(rx), .tx_o(tx),
      .frame_timeout_select_i(tsel), .address_source_select_i(src), .stored_addr_we_i(we_a),
      .stored_slave_address_i(st_a), .address_strap_2_i(strap[2]), .address_strap_1_i(strap[1]),
      .address_strap_0_i(strap[0]), .primary_flag_register_i(flag), .reg_we_o(we), .reg_re_o(re),
      .reg_addr_o(addr), .reg_wdata_o(wdat), .reg_rdata_i(rdat), .watchdog_restart_o(wd_p),
      .crc_error_o(crc_e), .slave_address_o(sa), .pwm_clk_o(pclk), .pwm_in_o(pin));
   lds_host_model #(.BIT(200)) lds_host_model_i (.clk_sys_i(clk), .tx_i(tx), .line_o(rx));

   assign rdat = mem[addr];
   always @(posedge clk) begin
      if (we === 1'b1) mem[addr] <= wdat;
      if (wd_p === 1'b1) n_wd++;
      if (crc_e === 1'b1) n_crc++;
      if (re === 1'b1) n_re++;
   end

   function automatic logic [7:0] crc_step(logic [7:0] c, logic [7:0] d);
      c = c ^ d;
      repeat (8) c = c[7] ? ({c[6:0], 1'b0} ^ CRC_POLY) : {c[6:0], 1'b0};
      return c;
   endfunction

   // Sends one frame and checks the answer, or its absence when none is set.
   task automatic xfer(input logic [7:0] sel, ptr, bad, input logic none);
      int n, nd;
      logic [7:0] c, b;
      logic ok;
      n = 1 << sel[5:4];
      nd = sel[7] ? n : 0;
      c = CRC_INIT;
      lds_host_model_i.send_byte(8'h55);
      for (int i = 0; i < nd + 2; i++) begin
         b = (i == 0) ? sel : (i == 1) ? ptr : wd[i-2];
         lds_host_model_i.send_byte(b);
         c = crc_step(c, b);
         if (i > 1 && bad == 8'h00) exp[8'(ptr + i - 2)] = b;
      end
      lds_host_model_i.send_byte(c ^ bad);
      for (int i = 0; i <= n - nd; i++) begin
         lds_host_model_i.recv_byte(b, ok);
         if (none) begin
            `CHK(ok, 1'b0)
            break;
         end
         `CHK(ok, 1'b1)
         `CHK(b, (i == n - nd) ? flag : exp[8'(ptr + i)])
      end
   endtask

   task automatic end_sim;
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   initial begin
      for (int i = 0; i < 256; i++) begin
         mem[i] = 8'(i) ^ 8'h5a;
         exp[i] = mem[i];
      end
      for (int k = 0; k < 8; k++) wd[k] = 8'(8'h91 + 8'h13 * k);
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      repeat (6) @(posedge clk);
      `CHK(sa, 4'h0)
      st_a <= 4'h5;
      we_a <= 1'b1;
      @(posedge clk) we_a <= 1'b0;
      repeat (6) @(posedge clk);
      `CHK(sa, 4'h5)
      `CHK({pclk, pin}, 3'b101)
      xfer(8'hb5, 8'hfc, 8'h00, 1'b0);
      xfer(8'h15, 8'hff, 8'h00, 1'b0);
      xfer(8'h05, 8'h40, 8'h01, 1'b1);
      `CHK(n_crc, 1)
      tsel <= 2'h1;
      lds_host_model_i.send_byte(8'h55);
      // The wait lies between the two timeouts, so only the selected one flushes the cut frame.
      repeat (3500) @(posedge clk);
      src <= 1'b0;
      strap <= 3'b010;
      repeat (6) @(posedge clk);
      `CHK(sa, 4'h2)
      `CHK({pclk, pin}, 3'b000)
      flag <= 8'hc3;
      xfer(8'ha2, 8'h10, 8'h00, 1'b0);
      xfer(8'h02, 8'h13, 8'h00, 1'b0);
      strap <= 3'b000;
      repeat (6) @(posedge clk);
      xfer(8'hc0, 8'h20, 8'h00, 1'b1);
      `CHK(mem[8'h20], wd[0])
      `CHK(n_wd, 5)
      `CHK(n_re, 3)
      end_sim();
   end

   initial begin
      repeat (99000) @(posedge clk);
      error_cnt++;
      end_sim();
   end
endmodule // lds_frame_slave_test
`default_nettype wire
